// ===== verilog/tps_defines.vh
// Timing constants for the self-test pattern and status outputs.
// Assumes a 100 MHz system clock (10 ns period).
`ifndef TPS_DEFINES_VH
`define TPS_DEFINES_VH
`define TPS_CLK_PERIOD_NS 10
`define TPS_PATTERN_PERIOD_NS 100
`define TPS_PATTERN_HIGH_NS 40
`define TPS_PATTERN_CYCLES (`TPS_PATTERN_PERIOD_NS / `TPS_CLK_PERIOD_NS)
`define TPS_HIGH_CYCLES (`TPS_PATTERN_HIGH_NS / `TPS_CLK_PERIOD_NS)
`define TPS_PHASE_W 4
`define TPS_DIGIT_MAX 4'h9
`define TPS_MODE_NORMAL 1'b0
`define TPS_MODE_QUALIFIED 1'b1
// Divider phases, sized for the 4-bit phase register
`define TPS_LAST_PHASE 4'h9
`define TPS_FALL_PHASE 4'h3
`define TPS_STEP_PHASE 4'h2
`define TPS_PHASE_RESET 4'h9
`endif

// ===== verilog/tps_bcd_digit.v
// One decimal digit stage of the test counter.
// Assumes a one-cycle advance enable in the same clock domain.
`timescale 1ns/100ps
`include "tps_defines.vh"
module tps_bcd_digit (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Advance control
  input wire inc_i,
  // Digit value and carry
  output reg [3:0] digit_o,
  output wire carry_o
);
  // Carry out when the digit wraps from nine
  assign carry_o = inc_i & (digit_o == `TPS_DIGIT_MAX);

  // Digit counts zero to nine
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      digit_o <= 4'h0;
    end else if (inc_i) begin
      if (digit_o == `TPS_DIGIT_MAX) begin
        digit_o <= 4'h0;
      end else begin
        digit_o <= digit_o + 4'h1;
      end
    end
  end
endmodule

// ===== verilog/tps_test_outputs.v
// Self-test pattern generator with trigger and trace status outputs.
// Assumes acquisition events are one-cycle pulses from logic on clk_i.
// Pattern and count leave the block on one clock edge.
// What this block does
// - Eight-bit BCD counter drives data test connector
// - LSB on lowest pin, MSB on highest
// - Clock test waveform 100 ns, 40 high
// - Clock waveform and counter share one timing
// - Counter changes just after clock falling edge
// - Six counter LSBs on clock connector lines
// - Trigger output rises at armed trigger
// - Trigger output holds until delay expiry, then low
// - Normal recording: trace high at start
// - Normal recording: trace low at delay expiry
// - Qualified recording: trace pulses per stored sample
// - Qualified recording: last fall at delay expiry
`timescale 1ns/100ps
`include "tps_defines.vh"
module tps_test_outputs (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Acquisition events from the sequencer
  input wire armed_i,
  input wire trig_hit_i,
  input wire rec_start_i,
  input wire delay_done_i,
  input wire sample_wr_i,
  input wire qual_mode_i,
  // Data probe test connector
  output reg [7:0] data_test_o,
  // Clock probe test connector
  output reg [7:0] clk_test_o,
  // Status strobes
  output reg trig_o,
  output reg trace_o
);
  // Divider phases, sized to the phase register
  localparam [3:0] LAST_PHASE = `TPS_LAST_PHASE;
  localparam [3:0] FALL_PHASE = `TPS_FALL_PHASE;
  localparam [3:0] STEP_PHASE = `TPS_STEP_PHASE;
  localparam [3:0] PHASE_RESET = `TPS_PHASE_RESET;
  // Recording window states
  localparam [0:0] REC_IDLE = 1'b0;
  localparam [0:0] REC_BUSY = 1'b1;

  // Divider and window state
  reg [3:0] phase;
  reg [3:0] next_phase;
  reg rec_state;
  reg next_rec_state;
  // Next values of the registered outputs
  reg [7:0] next_data_test;
  reg [7:0] next_clk_test;
  reg next_trig;
  reg next_trace;
  // Counter digits and pattern level
  wire step;
  wire units_carry;
  wire [3:0] units;
  wire [3:0] tens;
  wire [7:0] count_word;
  wire pattern_level;

  // Phase that follows ph, wrapping after the last one
  function [3:0] phase_after;
    input [3:0] ph;
    begin
      if (ph == LAST_PHASE) begin
        phase_after = 4'h0;
      end else begin
        phase_after = ph + 4'h1;
      end
    end
  endfunction

  // Pattern level set by the edge that ends phase ph
  function level_after;
    input [3:0] ph;
    begin
      level_after = (ph == LAST_PHASE) | (ph < FALL_PHASE);
    end
  endfunction

  // Window open now, or opening on this edge
  function window_open;
    input state;
    input start;
    begin
      window_open = (state == REC_BUSY) | start;
    end
  endfunction

  // Phase divider next value, one timing source for everything
  always @* begin
    next_phase = phase_after(phase);
  end

  // Phase divider; reset value makes the first edge start a high phase
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= PHASE_RESET;
    end else begin
      phase <= next_phase;
    end
  end

  // Digits advance one edge ahead, so count and fall leave together
  assign step = (phase == STEP_PHASE);

  // Units and tens digits
  tps_bcd_digit u_units (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(step),
    .digit_o(units),
    .carry_o(units_carry)
  );
  tps_bcd_digit u_tens (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(units_carry),
    .digit_o(tens),
    .carry_o()
  );

  // Count word, tens high and units low
  assign count_word = {tens, units};

  // Pattern level for the coming edge
  assign pattern_level = level_after(phase);

  // Connector next values, count and pattern on the same edge
  always @* begin
    next_data_test = count_word;
    next_clk_test[1:0] = {2{pattern_level}};
    next_clk_test[7:2] = count_word[5:0];
  end

  // Data connector register
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_test_o <= 8'h00;
    end else begin
      data_test_o <= next_data_test;
    end
  end

  // Clock connector register
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_test_o <= 8'h00;
    end else begin
      clk_test_o <= next_clk_test;
    end
  end

  // Recording window, start to delay expiry; expiry wins
  always @* begin
    next_rec_state = rec_state;
    case (rec_state)
      REC_IDLE: begin
        if (rec_start_i & ~delay_done_i) begin
          next_rec_state = REC_BUSY;
        end
      end
      REC_BUSY: begin
        if (delay_done_i) begin
          next_rec_state = REC_IDLE;
        end
      end
      default: begin
        next_rec_state = REC_IDLE;
      end
    endcase
  end

  // Recording window register
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rec_state <= REC_IDLE;
    end else begin
      rec_state <= next_rec_state;
    end
  end

  // Trigger output: rises on armed hit, falls on delay expiry
  always @* begin
    next_trig = trig_o;
    if (delay_done_i) begin
      next_trig = 1'b0;
    end else if (armed_i & trig_hit_i) begin
      next_trig = 1'b1;
    end
  end

  // Trace output per recording mode
  always @* begin
    if (delay_done_i) begin
      next_trace = 1'b0;
    end else if (qual_mode_i == `TPS_MODE_QUALIFIED) begin
      next_trace = sample_wr_i & window_open(rec_state, rec_start_i);
    end else begin
      next_trace = window_open(rec_state, rec_start_i);
    end
  end

  // Trigger output register
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_o <= 1'b0;
    end else begin
      trig_o <= next_trig;
    end
  end

  // Trace output register
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trace_o <= 1'b0;
    end else begin
      trace_o <= next_trace;
    end
  end
endmodule

// ===== tb/tps_monitor.sv
// Checker for the test pattern and status outputs.
// Assumes a bind to the block, seeing its ports only.
`timescale 1ns/100ps
module tps_monitor (
  input wire clk_i, rst_i, armed_i, trig_hit_i, rec_start_i, delay_done_i,
  input wire sample_wr_i, qual_mode_i, trig_o, trace_o,
  input wire [7:0] data_test_o, clk_test_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire p = clk_test_o[0];
  wire [7:0] d = data_test_o;
  // Pattern shape, pin map and data edge
  a_clk_high: assert property ($rose(p) |-> p[*4] ##1 !p) else $error("high");
  a_clk_low: assert property ($fell(p) |-> (!p)[*6] ##1 p) else $error("low");
  a_pin_map: assert property (clk_test_o == {d[5:0], p, p}) else $error("pins");
  a_data_edge: assert property ($changed(d) |-> $fell(p)) else $error("edge");
  a_fall_step: assert property ($fell(p) |-> $changed(d)) else $error("step");
  a_bcd_range: assert property (d[3:0] <= 4'h9 && d[7:4] <= 4'h9) else $error("bcd");
  // Status strobes
  a_trig_set: assert property (armed_i & trig_hit_i & !delay_done_i |=> trig_o)
    else $error("trig");
  a_delay_clear: assert property (delay_done_i |=> !trig_o & !trace_o)
    else $error("clear");
  a_trace_start: assert property (rec_start_i & !qual_mode_i & !delay_done_i |=> trace_o)
    else $error("start");
  a_qual_pulse: assert property (trace_o & $past(qual_mode_i) |-> $past(sample_wr_i))
    else $error("qual");
endmodule
bind tps_test_outputs tps_monitor tps_monitor_inst (.*);

// ===== tb/tps_probe.sv
// Probe model: records the data word at each rise of the clock pattern.
// Assumes the block's outputs are seen on the system clock.
`timescale 1ns/100ps
module tps_probe (
  input wire clk_i,
  input wire [7:0] word_i,
  input wire pin_i,
  output reg [7:0] word_o,
  output reg vld_o
);
  reg last = 1'b1;
  // Sample while the pattern is high and data held
  always @(posedge clk_i) begin
    last <= pin_i;
    vld_o <= pin_i & ~last;
    word_o <= word_i;
  end
endmodule

// ===== tb/tps_test_outputs_test.sv
// Self-checking bench for the test pattern and status outputs.
// Assumes the block and the probe model are compiled first.
`timescale 1ns/100ps
module tps_test_outputs_test;
  reg clk_i, rst_i, armed_i, trig_hit_i, rec_start_i, delay_done_i, sample_wr_i, qual_mode_i;
  wire [7:0] data_test_o, clk_test_o, word;
  wire trig_o, trace_o, vld;
  integer failures, samples_checked, i, m, r, a;
  reg t, tr, rec;
  logic [7:0] pq[$];
  logic [1:0] sq[$];
  tps_test_outputs tps_test_outputs_inst (.*);
  tps_probe tps_probe_inst (.clk_i(clk_i), .word_i(data_test_o), .pin_i(clk_test_o[0]),
    .word_o(word), .vld_o(vld));
  task chk(input [7:0] s, e);
    samples_checked = samples_checked + 1;
    if (s !== e) begin
      failures = failures + 1;
      $display("[FAIL] %0t saw %h want %h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("checked %0d failed %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Oldest note against each captured word and status pair
  always @(negedge clk_i) begin
    if (vld === 1'b1 && pq.size() > 0) chk(word, pq.pop_front());
    if (sq.size() > 1) chk({6'h00, trig_o, trace_o}, {6'h00, sq.pop_front()});
  end
  // Reset, then random events in normal and qualified recording
  initial begin
    {rst_i, armed_i, trig_hit_i, rec_start_i, delay_done_i, sample_wr_i, qual_mode_i} = 7'h40;
    {failures, samples_checked, t, tr, rec} = 0;
    r = $urandom(13);
    for (i = 0; i < 105; i++) pq.push_back({4'(i % 100 / 10), 4'(i % 10)});
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (m = 0; m < 2; m++) begin
      for (i = 0; i < 600; i++) begin
        @(posedge clk_i);
        r = (i == 0) ? 3 : $urandom % 8;
        a = $urandom % 2;
        qual_mode_i <= m[0];
        armed_i <= a[0];
        trig_hit_i <= r == 1 && rec;
        rec_start_i <= r == 2;
        delay_done_i <= r == 3;
        sample_wr_i <= r > 5;
        t = (r == 3) ? 0 : (a && r == 1 && rec) ? 1 : t;
        rec = (r == 3) ? 0 : (r == 2) ? 1 : rec;
        tr = m ? rec && r > 5 : rec;
        sq.push_back({t, tr});
      end
      $display("status mode %0d done", m);
    end
    chk(8'(pq.size()), 8'h00);
    end_of_test;
  end
endmodule
